// *** fic_ctrl.sv ***
// Host controller that drives flash command sequences over a byte bus
`timescale 1ns/1ps
module fic_ctrl #(
  parameter int ERASE_CYC = fic_pkg::ERASE_TIME_NS / fic_pkg::CLK_NS
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [15:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [15:0]           reg_rdata,
  output fic_pkg::fic_bus_t     fl_bus,
  input  wire logic [7:0]       fl_rdata,
  output logic                  busy,
  output logic                  reset_unsafe
);

  // ---------------------------------------------------------------
  // Step table
  // ---------------------------------------------------------------
  function automatic fic_pkg::fic_step_t step_at(
    input fic_pkg::fic_op_t op,
    input logic [3:0]       i,
    input logic [15:0]      a,
    input logic [7:0]       d,
    input logic [1:0]       area
  );
    fic_pkg::fic_step_t s;
    logic [3:0]         n;
    logic [7:0]         c3;
    logic [7:0]         ctl;
    // Steps reach only the flash window; no vector or loader writes
    s = '{fic_pkg::K_END, 16'h0000, 8'h00, 2'h0};
    n = (op == fic_pkg::OP_PROG || op == fic_pkg::OP_SECURE) ? 4'h6
                                                             : 4'h8;
    c3 = (op == fic_pkg::OP_PROG)   ? fic_pkg::CMD_PROG :
         (op == fic_pkg::OP_SECURE) ? fic_pkg::CMD_SECURE :
         (op == fic_pkg::OP_ID)     ? fic_pkg::CMD_ID : fic_pkg::CMD_ERASE;
    ctl = 8'h00;
    ctl[fic_pkg::AREA_LSB +: 2] = area;
    if (op == fic_pkg::OP_READ) begin
      if (i == 4'h0) s = '{fic_pkg::K_RD, a, 8'h00, 2'h0};
    end else if (op > fic_pkg::OP_ID) begin
      s.kind = fic_pkg::K_END;
    end else if (i == 4'h0) begin
      ctl[fic_pkg::MODE_LSB +: 3] = fic_pkg::MODE_EN;
      s = '{fic_pkg::K_WR, fic_pkg::CTL1_ADDR, ctl, 2'h0};
    end else if (i == 4'h1) begin
      s = '{fic_pkg::K_WR, fic_pkg::COMMIT_ADDR, fic_pkg::COMMIT_KEY, 2'h0};
    end else if (i == 4'h2 || i == 4'h5 && n == 4'h8 && op != fic_pkg::OP_ID)
    begin
      s = '{fic_pkg::K_WR, fic_pkg::UNLOCK_A1, fic_pkg::UNLOCK_D1, 2'h0};
    end else if (i == 4'h3 || i == 4'h6 && n == 4'h8 && op != fic_pkg::OP_ID)
    begin
      s = '{fic_pkg::K_WR, fic_pkg::UNLOCK_A2, fic_pkg::UNLOCK_D2, 2'h0};
    end else if (i == 4'h4) begin
      s = '{fic_pkg::K_WR, fic_pkg::UNLOCK_A1, c3, 2'h0};
    end else if (i < n) begin
      unique case (op)
        fic_pkg::OP_PROG:   s = '{fic_pkg::K_WR, a, d, 2'h0};
        fic_pkg::OP_SECURE:
          s = '{fic_pkg::K_WR, fic_pkg::SEC_ADDR, fic_pkg::SEC_DATA, 2'h0};
        fic_pkg::OP_SERASE: s = '{fic_pkg::K_WR, a, fic_pkg::CMD_SECTOR,
                                  2'h0};
        fic_pkg::OP_CERASE: s = '{fic_pkg::K_WR, fic_pkg::UNLOCK_A1,
                                  fic_pkg::CMD_CHIP, 2'h0};
        default: begin
          s.kind = fic_pkg::K_RD;
          s.slot = 2'(i - 4'h4);
          s.addr = (i == 4'h5) ? fic_pkg::VENDOR_ADDR :
                   (i == 4'h6) ? fic_pkg::FID_ADDR : fic_pkg::SEC_ADDR;
        end
      endcase
    end else if (i == n) begin
      if (op == fic_pkg::OP_ID)
        s = '{fic_pkg::K_WR, fic_pkg::VENDOR_ADDR, fic_pkg::CMD_EXIT,
              2'h0};
      else
        s = '{fic_pkg::K_POLL, (op == fic_pkg::OP_SECURE) ?
              fic_pkg::SEC_ADDR : a, 8'h00, 2'h0};
    end else if (i == n + 4'h1) begin
      ctl[fic_pkg::MODE_LSB +: 3] = fic_pkg::MODE_DIS;
      s = '{fic_pkg::K_WR, fic_pkg::CTL1_ADDR, ctl, 2'h0};
    end else if (i == n + 4'h2) begin
      s = '{fic_pkg::K_WR, fic_pkg::COMMIT_ADDR, fic_pkg::COMMIT_KEY, 2'h0};
    end
    return s;
  endfunction : step_at

  // ---------------------------------------------------------------
  // Reset release and pin synchroniser
  // ---------------------------------------------------------------
  logic       rst_s1_q;
  logic       rst_n_q;
  logic [7:0] rd_s1_q;
  logic [7:0] rd_s2_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rd_s1_q <= 8'h00;
      rd_s2_q <= 8'h00;
    end else if (ce) begin
      rd_s1_q <= fl_rdata;
      rd_s2_q <= rd_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer and registers
  // ---------------------------------------------------------------
  fic_pkg::fic_ctx_t  r_q;
  fic_pkg::fic_ctx_t  r_d;
  fic_pkg::fic_step_t st;
  logic               erase;
  logic [21:0]        limit;

  assign st    = step_at(r_q.op, r_q.idx, r_q.addr, r_q.data, r_q.area);
  assign erase = r_q.op == fic_pkg::OP_SERASE || r_q.op == fic_pkg::OP_CERASE;
  assign limit = erase ? 22'(ERASE_CYC) : 22'(fic_pkg::SEC_CYC);

  always_comb begin
    r_d        = r_q;
    r_d.bus.wr = 1'b0;
    r_d.bus.rd = 1'b0;
    r_d.rdata  = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        fic_pkg::R_CMD:      r_d.rdata = {8'h00, r_q.area, 3'h0, r_q.op};
        fic_pkg::R_ADDR:     r_d.rdata = r_q.addr;
        fic_pkg::R_DATA:     r_d.rdata = {8'h00, r_q.data};
        fic_pkg::R_STATUS:   r_d.rdata = {11'h000, r_q.lock, r_q.ver_err,
                                          r_q.tmo_err, r_q.done, busy};
        fic_pkg::R_RESULT:   r_d.rdata = {8'h00, r_q.result};
        fic_pkg::R_IDENT:    r_d.rdata = {r_q.vendor, r_q.fid};
        fic_pkg::R_SECURITY: r_d.rdata = {8'h00, r_q.secb};
        default:             r_d.rdata = 16'h0000;
      endcase
    end
    unique case (r_q.st)
      fic_pkg::S_IDLE: begin
        if (reg_wr && reg_addr == fic_pkg::R_ADDR) r_d.addr = reg_wdata;
        if (reg_wr && reg_addr == fic_pkg::R_DATA) r_d.data = reg_wdata[7:0];
        if (reg_wr && reg_addr == fic_pkg::R_CMD) begin
          r_d.op      = fic_pkg::fic_op_t'(reg_wdata[2:0]);
          r_d.area    = reg_wdata[5:4];
          r_d.idx     = 4'h0;
          r_d.phase   = 1'b0;
          r_d.tmo     = 22'h000000;
          r_d.done    = 1'b0;
          r_d.tmo_err = 1'b0;
          r_d.ver_err = 1'b0;
          r_d.st      = fic_pkg::S_STEP;
        end
      end
      fic_pkg::S_STEP: begin
        r_d.bus.addr  = st.addr;
        r_d.bus.wdata = st.data;
        r_d.st        = fic_pkg::S_WAIT;
        unique case (st.kind)
          fic_pkg::K_WR: begin
            r_d.bus.wr = 1'b1;
            r_d.lat    = fic_pkg::WR_GAP;
          end
          fic_pkg::K_RD, fic_pkg::K_POLL: begin
            r_d.bus.rd = 1'b1;
            r_d.lat    = fic_pkg::RD_LAT;
          end
          fic_pkg::K_END: begin
            r_d.done = 1'b1;
            r_d.st   = fic_pkg::S_IDLE;
          end
        endcase
      end
      fic_pkg::S_WAIT: begin
        r_d.lat = r_q.lat - 3'h1;
        if (st.kind == fic_pkg::K_POLL) r_d.tmo = r_q.tmo + 22'h000001;
        if (r_q.lat == 3'h1) begin
          r_d.st  = fic_pkg::S_STEP;
          r_d.idx = r_q.idx + 4'h1;
          if (st.kind == fic_pkg::K_RD) begin
            unique case (st.slot)
              2'h0: r_d.result = rd_s2_q;
              2'h1: r_d.vendor = rd_s2_q;
              2'h2: r_d.fid    = rd_s2_q;
              2'h3: begin
                r_d.secb = rd_s2_q;
                r_d.lock = rd_s2_q != fic_pkg::SEC_OFF;
              end
            endcase
          end else if (st.kind == fic_pkg::K_POLL) begin
            // Toggling bit makes two successive reads differ while busy
            r_d.first = rd_s2_q;
            r_d.phase = 1'b1;
            if (r_q.phase && rd_s2_q == r_q.first) begin
              r_d.phase  = 1'b0;
              r_d.result = rd_s2_q;
              if (erase && rd_s2_q != fic_pkg::ERASED)
                r_d.ver_err = 1'b1;
              if (r_q.op == fic_pkg::OP_SECURE) r_d.lock = 1'b1;
              if (r_q.op == fic_pkg::OP_CERASE) r_d.lock = 1'b0;
            end else if (r_q.tmo >= limit) begin
              r_d.tmo_err = 1'b1;
              r_d.phase   = 1'b0;
            end else begin
              r_d.idx = r_q.idx;
            end
          end
        end
      end
      default: r_d.st = fic_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) r_q <= '0;
    else if (ce) r_q <= r_d;
  end

  assign reg_rdata    = r_q.rdata;
  assign fl_bus       = r_q.bus;
  assign busy         = r_q.st != fic_pkg::S_IDLE;
  assign reset_unsafe = busy;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_q || !ce);

  sequence s_wr(logic [15:0] a, logic [7:0] d);
    fl_bus.wr && fl_bus.addr == a && fl_bus.wdata == d;
  endsequence
  sequence s_rd(logic [15:0] a);
    fl_bus.rd && fl_bus.addr == a;
  endsequence

  a_strobe_pulse: assert property (
    (fl_bus.wr || fl_bus.rd) |=> !(fl_bus.wr || fl_bus.rd))
    else $error("bus strobe longer than one cycle");
  a_unlock_pair: assert property (
    s_wr(fic_pkg::UNLOCK_A1, fic_pkg::UNLOCK_D1)
      |-> ##2 s_wr(fic_pkg::UNLOCK_A2, fic_pkg::UNLOCK_D2))
    else $error("unlock pair broken");
  a_commit_enable: assert property (
    (fl_bus.wr && fl_bus.addr == fic_pkg::CTL1_ADDR &&
     fl_bus.wdata[7:5] == fic_pkg::MODE_EN)
      |-> ##2 s_wr(fic_pkg::COMMIT_ADDR, fic_pkg::COMMIT_KEY))
    else $error("enable not committed");
  a_commit_disable: assert property (
    (fl_bus.wr && fl_bus.addr == fic_pkg::CTL1_ADDR &&
     fl_bus.wdata[7:5] == fic_pkg::MODE_DIS)
      |-> ##2 s_wr(fic_pkg::COMMIT_ADDR, fic_pkg::COMMIT_KEY))
    else $error("disable not committed");
  a_id_reads: assert property (
    (s_rd(fic_pkg::VENDOR_ADDR) && r_q.op == fic_pkg::OP_ID)
      |-> ##5 s_rd(fic_pkg::FID_ADDR) ##5 s_rd(fic_pkg::SEC_ADDR))
    else $error("id read order broken");
  a_id_exit: assert property (
    (s_rd(fic_pkg::SEC_ADDR) && r_q.op == fic_pkg::OP_ID)
      |-> ##5 s_wr(fic_pkg::VENDOR_ADDR, fic_pkg::CMD_EXIT))
    else $error("id exit missing");
  a_unsafe_hold: assert property (
    fl_bus.wr |-> reset_unsafe [*2])
    else $error("reset window opened early");
  a_lock_clear: assert property (
    $fell(r_q.lock) |-> r_q.op inside {fic_pkg::OP_CERASE, fic_pkg::OP_ID})
    else $error("lock cleared by wrong operation");
  a_poll_bound: assert property (
    (r_q.op == fic_pkg::OP_SECURE) |-> r_q.tmo <= 22'(fic_pkg::SEC_CYC + 8))
    else $error("security poll overran");
  a_erase_ones: assert property (
    ($rose(r_q.done) && r_q.op == fic_pkg::OP_CERASE && !r_q.tmo_err &&
     !r_q.ver_err) |-> r_q.result == fic_pkg::ERASED)
    else $error("erase result not all ones");

endmodule : fic_ctrl

// *** fic_flash_model.sv ***
// Behavioural flash array that answers the host's byte bus
`timescale 1ns/1ps
module fic_flash_model #(
  parameter logic [7:0] VENDOR_CODE = 8'h3c, // Arbitrary value
  parameter logic [7:0] FLASH_CODE  = 8'h5a  // Arbitrary value
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire fic_pkg::fic_bus_t fl_bus,
  input  wire logic [15:0]       op_cycles,
  input  wire logic              stall,
  output logic [7:0]             fl_rdata
);
  // ---------------------------------------------------------------
  // Array, mode and command state
  // ---------------------------------------------------------------
  logic [7:0]  mem [0:65535];
  logic [7:0]  ctl_q;
  logic [7:0]  d;
  logic [2:0]  mode_q;
  logic [2:0]  seq_q;
  logic [15:0] busy_q;
  logic [15:0] a;
  logic [1:0]  hold_q;
  logic        id_q; // Boot and loader steps lie off this bus
  logic        lock_q = 1'b0; // Parallel and serial gating absent
  logic        tog_q;
  logic        fresh_q;
  logic        t;
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_q <= 8'h00;
      mode_q <= fic_pkg::MODE_DIS;
      seq_q <= 3'h0;
      busy_q <= 16'h0000;
      hold_q <= 2'h0;
      id_q <= 1'b0;
      tog_q <= 1'b0;
      fresh_q <= 1'b0;
      fl_rdata <= 8'h00;
    end else begin
      a = fl_bus.addr;
      d = fl_bus.wdata;
      if (busy_q != 16'h0000 && !stall) busy_q <= busy_q - 16'h0001;
      if (hold_q == 2'h1) fl_rdata <= ~fl_rdata;
      if (hold_q != 2'h0) hold_q <= hold_q - 2'h1;
      if (fl_bus.rd) begin
        hold_q <= 2'h3;
        if (busy_q != 16'h0000) begin
          t = fresh_q | (mode_q == fic_pkg::MODE_EN ? ~tog_q : tog_q);
          tog_q <= t;
          fresh_q <= 1'b0;
          fl_rdata <= {1'b0, t, 6'h00};
        end else if (id_q && a == fic_pkg::VENDOR_ADDR) begin
          fl_rdata <= VENDOR_CODE;
        end else if (id_q && a == fic_pkg::FID_ADDR) begin
          fl_rdata <= FLASH_CODE;
        end else if (id_q && a == fic_pkg::SEC_ADDR) begin
          fl_rdata <= lock_q ? 8'h00 : fic_pkg::SEC_OFF;
        end else begin
          fl_rdata <= mem[a];
        end
      end
      if (fl_bus.wr) begin
        if (a == fic_pkg::CTL1_ADDR) begin
          ctl_q <= d;
        end else if (a == fic_pkg::COMMIT_ADDR) begin
          if (d == fic_pkg::COMMIT_KEY) begin
            mode_q <= ctl_q[7:5];
          end
        end else if (mode_q == fic_pkg::MODE_EN && busy_q == 16'h0000) begin
          seq_q <= 3'h0;
          if (seq_q == 3'h0 && d == fic_pkg::CMD_EXIT) begin
            id_q <= 1'b0;
          end
          case (seq_q)
            3'h0, 3'h3: begin
              if (a == fic_pkg::UNLOCK_A1 && d == fic_pkg::UNLOCK_D1)
                seq_q <= seq_q + 3'h1;
            end
            3'h1, 3'h4: begin
              if (a == fic_pkg::UNLOCK_A2 && d == fic_pkg::UNLOCK_D2)
                seq_q <= seq_q + 3'h1;
            end
            3'h2: begin
              if (d == fic_pkg::CMD_PROG) seq_q <= 3'h6;
              if (d == fic_pkg::CMD_ERASE) seq_q <= 3'h3;
              if (d == fic_pkg::CMD_SECURE) seq_q <= 3'h7;
              if (d == fic_pkg::CMD_ID) id_q <= 1'b1;
            end
            3'h5: begin
              if (d == fic_pkg::CMD_SECTOR) begin
                for (int i = 0; i < 4096; i++)
                  mem[{a[15:12], 12'h000} + i] <= 8'hff;
              end
              if (d == fic_pkg::CMD_CHIP) begin
                for (int i = 0; i < 65536; i++) mem[i] <= 8'hff;
                lock_q <= 1'b0;
              end
            end
            3'h6: mem[a] <= d;
            default: begin
              if (a == fic_pkg::SEC_ADDR && d == fic_pkg::SEC_DATA)
                lock_q <= 1'b1;
            end
          endcase
          if (seq_q >= 3'h5) begin
            busy_q <= op_cycles;
            fresh_q <= 1'b1;
          end
        end
      end
    end
  end
endmodule : fic_flash_model

// *** fic_pkg.sv ***
// Constants and types for the flash command host
package fic_pkg;

  // ---------------------------------------------------------------
  // Device map and command codes
  // ---------------------------------------------------------------
  localparam logic [15:0] CTL1_ADDR   = 16'h0fe0;
  localparam logic [15:0] COMMIT_ADDR = 16'h0fe1;
  localparam int          MODE_LSB    = 5;
  localparam int          AREA_LSB    = 2;
  localparam logic [2:0]  MODE_EN     = 3'h5;
  localparam logic [2:0]  MODE_DIS    = 3'h2;
  localparam logic [7:0]  COMMIT_KEY  = 8'hd5;
  localparam logic [15:0] UNLOCK_A1   = 16'hf555;
  localparam logic [15:0] UNLOCK_A2   = 16'hfaaa;
  localparam logic [7:0]  UNLOCK_D1   = 8'haa;
  localparam logic [7:0]  UNLOCK_D2   = 8'h55;
  localparam logic [7:0]  CMD_PROG    = 8'ha0;
  localparam logic [7:0]  CMD_ERASE   = 8'h80;
  localparam logic [7:0]  CMD_SECTOR  = 8'h30;
  localparam logic [7:0]  CMD_CHIP    = 8'h10;
  localparam logic [7:0]  CMD_ID      = 8'h90;
  localparam logic [7:0]  CMD_EXIT    = 8'hf0;
  localparam logic [7:0]  CMD_SECURE  = 8'ha5;
  localparam logic [7:0]  SEC_DATA    = 8'h00;
  localparam logic [15:0] VENDOR_ADDR = 16'hf000;
  localparam logic [15:0] FID_ADDR    = 16'hf001;
  localparam logic [15:0] SEC_ADDR    = 16'hff7f;
  localparam logic [7:0]  SEC_OFF     = 8'hff;
  localparam logic [7:0]  ERASED      = 8'hff;

  // ---------------------------------------------------------------
  // Host registers and timing
  // ---------------------------------------------------------------
  localparam logic [3:0] R_CMD      = 4'h0;
  localparam logic [3:0] R_ADDR     = 4'h1;
  localparam logic [3:0] R_DATA     = 4'h2;
  localparam logic [3:0] R_STATUS   = 4'h3;
  localparam logic [3:0] R_RESULT   = 4'h4;
  localparam logic [3:0] R_IDENT    = 4'h5;
  localparam logic [3:0] R_SECURITY = 4'h6;
  localparam int         CLK_NS        = 10;
  localparam int         SEC_TIME_NS   = 40000;
  localparam int         SEC_CYC       = SEC_TIME_NS / CLK_NS;
  localparam int         ERASE_TIME_NS = 30000000;
  localparam logic [2:0] RD_LAT        = 3'h4;
  localparam logic [2:0] WR_GAP        = 3'h1;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ = 3'b000, OP_PROG = 3'b001, OP_SERASE = 3'b010,
    OP_CERASE = 3'b011, OP_SECURE = 3'b100, OP_ID = 3'b101
  } fic_op_t;
  typedef enum logic [1:0] {
    K_WR = 2'b00, K_RD = 2'b01, K_POLL = 2'b10, K_END = 2'b11
  } fic_kind_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_STEP = 2'b01, S_WAIT = 2'b10
  } fic_fsm_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fic_bus_t;
  typedef struct packed {
    fic_kind_t   kind;
    logic [15:0] addr;
    logic [7:0]  data;
    logic [1:0]  slot;
  } fic_step_t;
  typedef struct packed {
    fic_fsm_t    st;
    fic_op_t     op;
    logic [3:0]  idx;
    logic [15:0] addr;
    logic [7:0]  data;
    logic [1:0]  area;
    logic [2:0]  lat;
    logic        phase;
    logic [7:0]  first;
    logic [21:0] tmo;
    logic        done;
    logic        tmo_err;
    logic        ver_err;
    logic        lock;
    logic [7:0]  result;
    logic [7:0]  vendor;
    logic [7:0]  fid;
    logic [7:0]  secb;
    fic_bus_t    bus;
    logic [15:0] rdata;
  } fic_ctx_t;

endpackage : fic_pkg

// *** test_flash_id_security_toggle_ctrl.sv ***
// Self-checking bench for the flash command host
`timescale 1ns/1ps
module test_flash_id_security_toggle_ctrl;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  localparam logic [7:0] VC = 8'h3c; // Arbitrary value
  localparam logic [7:0] FC = 8'h5a; // Arbitrary value
  logic              ref_clk;
  logic              resetn;
  logic              ce;
  logic              reg_wr;
  logic              reg_rd;
  logic              busy;
  logic              reset_unsafe;
  logic              stall;
  logic [3:0]        reg_addr;
  logic [15:0]       reg_wdata;
  logic [15:0]       reg_rdata;
  logic [15:0]       op_cycles;
  logic [7:0]        fl_rdata;
  fic_pkg::fic_bus_t fl_bus;
  int                err_total;
  int                checks;
  fic_ctrl #(.ERASE_CYC(200)) dut (.ref_clk(ref_clk), .resetn(resetn),
    .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fl_bus(fl_bus),
    .fl_rdata(fl_rdata), .busy(busy), .reset_unsafe(reset_unsafe));
  fic_flash_model #(.VENDOR_CODE(VC), .FLASH_CODE(FC)) mdl (
    .ref_clk(ref_clk), .resetn(resetn), .fl_bus(fl_bus),
    .op_cycles(op_cycles), .stall(stall), .fl_rdata(fl_rdata));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic expect_reg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    check(reg_rdata, exp);
  endtask : expect_reg
  task automatic start_op(input logic [2:0] op, input logic [15:0] a,
                          input logic [7:0] d);
    reg_write(fic_pkg::R_ADDR, a);
    reg_write(fic_pkg::R_DATA, {8'h00, d});
    reg_write(fic_pkg::R_CMD, {13'h0000, op});
  endtask : start_op
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (2) @(negedge ref_clk);
    while (busy !== 1'b0 && n < 9000) begin
      check({15'h0000, reset_unsafe}, 16'h0001);
      @(negedge ref_clk);
      n++;
    end
    check({15'h0000, busy}, 16'h0000);
    check({15'h0000, reset_unsafe}, 16'h0000);
  endtask : wait_idle
  task automatic run_op(input logic [2:0] op, input logic [15:0] a,
                        input logic [7:0] d);
    start_op(op, a, d);
    wait_idle();
  endtask : run_op
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    check({15'h0000, busy}, 16'h0000);
    expect_reg(fic_pkg::R_STATUS, 16'h0000);
    expect_reg(4'hf, 16'h0000);
    @(negedge ref_clk);
    check(reg_rdata, 16'h0000);
    @(posedge ref_clk);
    ce <= 1'b0;
    reg_write(fic_pkg::R_ADDR, 16'h5555);
    @(posedge ref_clk);
    ce <= 1'b1;
    expect_reg(fic_pkg::R_ADDR, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_program;
    op_cycles <= 16'd150;
    start_op(3'h1, 16'he501, 8'h12);
    reg_write(fic_pkg::R_ADDR, 16'h1234);
    wait_idle();
    expect_reg(fic_pkg::R_STATUS, 16'h0002);
    expect_reg(fic_pkg::R_ADDR, 16'he501);
    expect_reg(fic_pkg::R_CMD, 16'h0001);
    expect_reg(fic_pkg::R_DATA, 16'h0012);
    check({8'h00, mdl.mem[16'he501]}, 16'h0012);
    check({8'h00, mdl.mem[16'h1234]}, 16'h00ff);
    check(16'(mdl.mode_q), 16'(fic_pkg::MODE_DIS));
    op_cycles <= 16'd1;
    run_op(3'h1, 16'he500, 8'h3f);
    expect_reg(fic_pkg::R_STATUS, 16'h0002);
    run_op(3'h0, 16'he501, 8'h00);
    expect_reg(fic_pkg::R_RESULT, 16'h0012);
    op_cycles <= 16'd20;
    run_op(3'h2, 16'he000, 8'h00);
    expect_reg(fic_pkg::R_STATUS, 16'h0002);
    run_op(3'h0, 16'he500, 8'h00);
    expect_reg(fic_pkg::R_RESULT, 16'h00ff);
    run_op(3'h6, 16'h0000, 8'h00);
    expect_reg(fic_pkg::R_STATUS, 16'h0002);
    $display("test program done");
  endtask : t_program
  task automatic t_identify(input logic [15:0] sec, input logic [15:0] st);
    run_op(3'h5, 16'h0000, 8'h00);
    expect_reg(fic_pkg::R_IDENT, {VC, FC});
    expect_reg(fic_pkg::R_SECURITY, sec);
    expect_reg(fic_pkg::R_STATUS, st);
    check({15'h0000, mdl.id_q}, 16'h0000);
    $display("test identify done");
  endtask : t_identify
  task automatic t_lock;
    run_op(3'h4, fic_pkg::SEC_ADDR, fic_pkg::SEC_DATA);
    expect_reg(fic_pkg::R_STATUS, 16'h0012);
    run_op(3'h2, 16'he000, 8'h00);
    expect_reg(fic_pkg::R_STATUS, 16'h0012);
    t_identify(16'h0000, 16'h0012);
    run_op(3'h3, 16'he000, 8'h00);
    expect_reg(fic_pkg::R_STATUS, 16'h0002);
    t_identify(16'h00ff, 16'h0002);
    $display("test lock done");
  endtask : t_lock
  task automatic t_timeout;
    stall <= 1'b1;
    run_op(3'h1, 16'he600, 8'h01);
    expect_reg(fic_pkg::R_STATUS, 16'h0006);
    stall <= 1'b0;
    $display("test timeout done");
  endtask : t_timeout
  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    ce = 1'b1;
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    op_cycles = 16'd20;
    stall = 1'b0;
    err_total = 0;
    checks = 0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_program();
    t_identify(16'h00ff, 16'h0002);
    t_lock();
    t_timeout();
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    check(16'h0000, 16'h0001);
    tally_and_finish();
  end
endmodule : test_flash_id_security_toggle_ctrl
